// ---- hdl/dsr_top.sv ----
// status and interrupt readback register bank of the video decoder
module dsr_top
   import dsr_pkg::*;
#(
   parameter logic [7:0] ROM_REVISION = 8'h5a  // arbitrary value
) (
   input  wire logic                  clk,
   input  wire logic                  rst_n,
   input  wire dsr_req_t              req,
   output logic [7:0]                 rd_data,
   output logic                       rd_valid,
   input  wire dsr_status_t           status,
   input  wire logic [7:0]            ram_revision,
   input  wire logic                  line_start,
   input  wire logic                  frame_start,
   input  wire logic                  irq_pin_in,
   output logic                       irq_pin_out,
   output logic                       irq_pin_oe,
   output logic                       irq_asserted,
   output logic [DSR_PROD_W-1:0]      gain_product
);

   ////////////////////////////////////////////////////////////////////////
   // register state
   logic [7:0]            rd_data_ff;
   logic                  rd_valid_ff;
   logic                  polarity_ff;
   logic                  lost_lock_ff;
   logic [2:0]            lock_prev_ff;
   logic [DSR_LINE_W-1:0] line_cnt_ff;
   logic [DSR_LINE_W-1:0] line_count_ff;
   logic [7:0]            ram_rev_ff;
   logic                  irq_active_ff;
   logic                  irq_out_ff;
   logic                  irq_oe_ff;
   logic [DSR_PROD_W-1:0] gain_product_ff;

   ////////////////////////////////////////////////////////////////////////
   // access decode
   logic wr_irq_reset;
   logic wr_config;
   logic rd_lock_status;

   // only the reset and config subaddresses accept writes here
   // a write anywhere else is dropped, so readback values never change
   assign wr_irq_reset   = req.wr & (req.addr == DSR_OFS_IRQ_RESET);
   assign wr_config      = req.wr & (req.addr == DSR_OFS_IRQ_CONFIG);
   assign rd_lock_status = req.rd & (req.addr == DSR_OFS_LOCK_STATUS);

   ////////////////////////////////////////////////////////////////////////
   // change flags of the second interrupt source register
   logic [7:0] irq_clr;
   logic [7:0] irq_flags;
   logic       nxt_irq_active;

   assign irq_clr = wr_irq_reset ? req.wdata : 8'h00;

   dsr_change_flag #(.W(3)) u_flag_copy_prot (
      .clk   (clk),
      .rst_n (rst_n),
      .level (status.copy_prot),
      .clr   (irq_clr[DSR_IRQ_COPY_PROT]),
      .flag  (irq_flags[DSR_IRQ_COPY_PROT])
   );

   dsr_change_flag #(.W(1)) u_flag_field_rate (
      .clk   (clk),
      .rst_n (rst_n),
      .level (status.field_50hz),
      .clr   (irq_clr[DSR_IRQ_FIELD_RATE]),
      .flag  (irq_flags[DSR_IRQ_FIELD_RATE])
   );

   dsr_change_flag #(.W(1)) u_flag_line_alt (
      .clk   (clk),
      .rst_n (rst_n),
      .level (status.line_alt),
      .clr   (irq_clr[DSR_IRQ_LINE_ALT]),
      .flag  (irq_flags[DSR_IRQ_LINE_ALT])
   );

   dsr_change_flag #(.W(1)) u_flag_colour (
      .clk   (clk),
      .rst_n (rst_n),
      .level (status.subcarrier_lock),
      .clr   (irq_clr[DSR_IRQ_COLOUR]),
      .flag  (irq_flags[DSR_IRQ_COLOUR])
   );

   dsr_change_flag #(.W(2)) u_flag_sync_lock (
      .clk   (clk),
      .rst_n (rst_n),
      .level ({status.hsync_lock, status.vsync_lock}),
      .clr   (irq_clr[DSR_IRQ_SYNC_LOCK]),
      .flag  (irq_flags[DSR_IRQ_SYNC_LOCK])
   );

   dsr_change_flag #(.W(1)) u_flag_source (
      .clk   (clk),
      .rst_n (rst_n),
      .level (status.source_class),
      .clr   (irq_clr[DSR_IRQ_SOURCE]),
      .flag  (irq_flags[DSR_IRQ_SOURCE])
   );

   // bit 7 is a live readiness level, bit 5 reserved and reads zero
   assign irq_flags[DSR_IRQ_INIT_READY] = status.init_done;
   assign irq_flags[5]                  = 1'b0;

   // any pending change drives the pin; readiness is status only
   assign nxt_irq_active = |irq_flags[DSR_IRQ_COPY_PROT:DSR_IRQ_SOURCE];

   ////////////////////////////////////////////////////////////////////////
   // interrupt pin drive
   logic nxt_irq_out;
   logic nxt_irq_oe;

   // open-drain when active low: pull low only while active, else release
   assign nxt_irq_out = polarity_ff ? nxt_irq_active : 1'b0;
   assign nxt_irq_oe  = polarity_ff ? 1'b1 : nxt_irq_active;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         irq_active_ff <= 1'b0;
         irq_out_ff    <= 1'b0;
         irq_oe_ff     <= 1'b0;
      end else begin
         irq_active_ff <= nxt_irq_active;
         irq_out_ff    <= nxt_irq_out;
         irq_oe_ff     <= nxt_irq_oe;
      end
   end

   // pin level as seen on the wire, so 0x87 reports the terminal itself
   // limitation: right after a polarity write 0x87 may read inverted for one cycle
   logic pin_asserted;

   assign pin_asserted = polarity_ff ? (irq_pin_in & irq_oe_ff)
                                     : (~irq_pin_in & irq_oe_ff);

   ////////////////////////////////////////////////////////////////////////
   // configuration register
   // polarity reads back at 0x1e so the host can confirm the pin mode
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         polarity_ff <= DSR_CFG_POLARITY_RST;
      end else if (wr_config) begin
         polarity_ff <= req.wdata[DSR_CFG_POLARITY_BIT];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // sticky lost-lock detect
   logic [2:0] lock_now;
   logic       lock_fell;
   logic       nxt_lost_lock;

   // a fall of any of the three locks counts as a lost lock
   assign lock_now      = {status.subcarrier_lock, status.vsync_lock, status.hsync_lock};
   assign lock_fell     = |(lock_prev_ff & ~lock_now);
   // a loss in the reading cycle survives the read's clear
   assign nxt_lost_lock = lock_fell | (lost_lock_ff & ~rd_lock_status);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         lock_prev_ff <= 3'h0;
         lost_lock_ff <= 1'b0;
      end else begin
         lock_prev_ff <= lock_now;
         lost_lock_ff <= nxt_lost_lock;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // measured lines per frame
   logic [DSR_LINE_W-1:0] nxt_line_cnt;
   logic                  line_sat;

   // saturate rather than wrap so a runaway source reads as the maximum
   assign line_sat     = (line_cnt_ff == DSR_LINE_MAX);
   assign nxt_line_cnt = frame_start ? DSR_LINE_ONE
                       : (line_start && !line_sat) ? line_cnt_ff + DSR_LINE_ONE
                       : line_cnt_ff;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         line_cnt_ff   <= '0;
         line_count_ff <= '0;
      end else begin
         line_cnt_ff <= nxt_line_cnt;
         // the count only moves here, so 0x84 and 0x85 pair up within one frame
         if (frame_start) begin
            line_count_ff <= line_cnt_ff;
         end
      end
   end

   // patch revision is sampled so a load in progress never tears a read
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ram_rev_ff <= 8'h00;
      end else begin
         ram_rev_ff <= ram_revision;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // gain product, fixed point over 15 * 4096
   logic [5:0]            gain_step;
   logic [5:0]            analog_term;
   logic [12:0]           digital_term;
   logic [DSR_PROD_W-1:0] nxt_gain_product;

   assign gain_step        = DSR_GAIN_STEP[status.analog_gain];
   // operands widened before each multiply so no tool sizes a product too narrow
   assign analog_term      = DSR_ANALOG_BASE + {1'b0, status.analog_gain, 1'b0} + {2'b00, status.analog_gain};
   assign digital_term     = DSR_DIGITAL_BASE + 13'(gain_step) * 13'(status.digital_gain);
   assign nxt_gain_product = DSR_PROD_W'(analog_term) * DSR_PROD_W'(digital_term);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         gain_product_ff <= '0;
      end else begin
         gain_product_ff <= nxt_gain_product;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // read data assembly
   logic [7:0] lock_byte;
   logic [7:0] signal_byte;
   logic [7:0] gain_byte;
   logic [7:0] config_byte;
   logic [7:0] rd_mux;

   // live levels pass straight through; only lost-lock and polarity are stored values
   assign lock_byte = {status.peak_white, status.line_alt, status.field_50hz, lost_lock_ff,
                       status.subcarrier_lock, status.vsync_lock, status.hsync_lock,
                       status.source_class};
   assign signal_byte = {1'b0, status.weak_signal, status.phase_alternation_toggle,
                         status.odd_field, status.gain_frozen, status.copy_prot};
   assign gain_byte   = {status.analog_gain, status.digital_gain[5:2]};
   assign config_byte = {7'h00, polarity_ff};

   // unmapped and write-only subaddresses read as zero
   assign rd_mux =
      (req.addr == DSR_OFS_ROM_REV)     ? ROM_REVISION :
      (req.addr == DSR_OFS_RAM_REV)     ? ram_rev_ff :
      (req.addr == DSR_OFS_LINE_HIGH)   ? {6'h00, line_count_ff[9:8]} :
      (req.addr == DSR_OFS_LINE_LOW)    ? line_count_ff[7:0] :
      (req.addr == DSR_OFS_IRQ_FLAGS)   ? irq_flags :
      (req.addr == DSR_OFS_IRQ_ACTIVE)  ? {7'h00, pin_asserted} :
      (req.addr == DSR_OFS_LOCK_STATUS) ? lock_byte :
      (req.addr == DSR_OFS_SIGNAL_STAT) ? signal_byte :
      (req.addr == DSR_OFS_GAIN_READ)   ? gain_byte :
      (req.addr == DSR_OFS_IRQ_CONFIG)  ? config_byte :
      8'h00;

   // read data holds until the next read; writes elsewhere change nothing
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rd_data_ff  <= DSR_RDATA_RST;
         rd_valid_ff <= 1'b0;
      end else begin
         rd_valid_ff <= req.rd;
         if (req.rd) begin
            rd_data_ff <= rd_mux;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // outputs, all straight from flip-flops
   assign rd_data      = rd_data_ff;
   assign rd_valid     = rd_valid_ff;
   assign irq_pin_out  = irq_out_ff;
   assign irq_pin_oe   = irq_oe_ff;
   assign irq_asserted = irq_active_ff;
   assign gain_product = gain_product_ff;

endmodule : dsr_top

// ---- hdl/dsr_pkg.sv ----
// package: offsets, field positions, reset values and carrier types of the status readback bank
package dsr_pkg;

   // register subaddresses on the serial control port
   localparam logic [7:0] DSR_OFS_IRQ_RESET    = 8'h1c;
   localparam logic [7:0] DSR_OFS_IRQ_CONFIG   = 8'h1e;
   localparam logic [7:0] DSR_OFS_ROM_REV      = 8'h82;
   localparam logic [7:0] DSR_OFS_RAM_REV      = 8'h83;
   localparam logic [7:0] DSR_OFS_LINE_HIGH    = 8'h84;
   localparam logic [7:0] DSR_OFS_LINE_LOW     = 8'h85;
   localparam logic [7:0] DSR_OFS_IRQ_FLAGS    = 8'h86;
   localparam logic [7:0] DSR_OFS_IRQ_ACTIVE   = 8'h87;
   localparam logic [7:0] DSR_OFS_LOCK_STATUS  = 8'h88;
   localparam logic [7:0] DSR_OFS_SIGNAL_STAT  = 8'h89;
   localparam logic [7:0] DSR_OFS_GAIN_READ    = 8'h8a;

   // interrupt flag register bit positions
   localparam int DSR_IRQ_INIT_READY = 7;
   localparam int DSR_IRQ_COPY_PROT  = 6;
   localparam int DSR_IRQ_FIELD_RATE = 4;
   localparam int DSR_IRQ_LINE_ALT   = 3;
   localparam int DSR_IRQ_COLOUR     = 2;
   localparam int DSR_IRQ_SYNC_LOCK  = 1;
   localparam int DSR_IRQ_SOURCE     = 0;

   // configuration field and reset values
   localparam int         DSR_CFG_POLARITY_BIT = 0;
   localparam logic       DSR_CFG_POLARITY_RST = 1'b0;
   localparam logic [7:0] DSR_RDATA_RST        = 8'h00;

   // line counter limits
   localparam int          DSR_LINE_W   = 10;
   localparam logic [9:0]  DSR_LINE_MAX = 10'h3ff;
   localparam logic [9:0]  DSR_LINE_ONE = 10'h001;

   // gain product terms: gain = product / (15 * 4096)
   localparam int          DSR_PROD_W        = 19;
   localparam logic [5:0]  DSR_ANALOG_BASE   = 6'h0f;
   localparam logic [12:0] DSR_DIGITAL_BASE  = 13'h1000;
   localparam logic [17:0] DSR_GAIN_DIVISOR  = 18'h0f000;

   // digital gain step chosen by the analog gain setting, index 0..15
   localparam logic [5:0] DSR_GAIN_STEP [16] = '{
      6'h3d, 6'h37, 6'h30, 6'h2c, 6'h26, 6'h21, 6'h1d, 6'h1a,
      6'h18, 6'h16, 6'h14, 6'h13, 6'h12, 6'h11, 6'h10, 6'h0f};

   // live status levels from the decoder core
   typedef struct packed {
      logic       init_done;
      logic       peak_white;
      logic       line_alt;
      logic       field_50hz;
      logic       subcarrier_lock;
      logic       vsync_lock;
      logic       hsync_lock;
      logic       source_class;
      logic       weak_signal;
      logic       phase_alternation_toggle;
      logic       odd_field;
      logic       gain_frozen;
      logic [2:0] copy_prot;
      logic [3:0] analog_gain;
      logic [5:0] digital_gain;
   } dsr_status_t;

   // host register access request
   typedef struct packed {
      logic       rd;
      logic       wr;
      logic [7:0] addr;
      logic [7:0] wdata;
   } dsr_req_t;

endpackage : dsr_pkg

// ---- hdl/dsr_change_flag.sv ----
// sticky change detector: flags any change of a status level until cleared
module dsr_change_flag
   import dsr_pkg::*;
#(
   parameter int W = 1
) (
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic [W-1:0] level,
   input  wire logic         clr,
   output logic              flag
);

   logic [W-1:0] prev_ff;
   logic         flag_ff;
   logic         changed;
   logic         nxt_flag;

   // a change in the clearing cycle still sets: set wins over clear
   assign changed  = |(level ^ prev_ff);
   assign nxt_flag = changed | (flag_ff & ~clr);
   assign flag     = flag_ff;

   ////////////////////////////////////////////////////////////////////////
   // previous level and sticky flag
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         prev_ff <= '0;
         flag_ff <= 1'b0;
      end else begin
         prev_ff <= level;
         flag_ff <= nxt_flag;
      end
   end

endmodule : dsr_change_flag

// ---- verif/dsr_top_asserts.sv ----
// checker: port-level assertions of the status readback bank
module dsr_top_asserts
   import dsr_pkg::*;
#(
   parameter logic [7:0] ROM_REVISION = 8'h5a
) (
   input wire logic                  clk,
   input wire logic                  rst_n,
   input wire dsr_req_t              req,
   input wire logic [7:0]            rd_data,
   input wire logic                  rd_valid,
   input wire dsr_status_t           status,
   input wire logic [7:0]            ram_revision,
   input wire logic                  irq_pin_out,
   input wire logic                  irq_pin_oe,
   input wire logic                  irq_asserted,
   input wire logic [DSR_PROD_W-1:0] gain_product
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [DSR_PROD_W-1:0] exp_gain;
   logic [8:0]            src;
   // expected product and the levels whose change raises a flag
   assign exp_gain = DSR_PROD_W'((15 + 3 * status.analog_gain)
                     * (4096 + DSR_GAIN_STEP[status.analog_gain] * status.digital_gain));
   assign src = {status.copy_prot, status.field_50hz, status.line_alt, status.subcarrier_lock,
                 status.vsync_lock, status.hsync_lock, status.source_class};
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);
   ////////////////////////////////////////////////////////////////////////////
   chk_rom_read: assert property (req.rd && req.addr == DSR_OFS_ROM_REV |=> rd_data == ROM_REVISION)
      else $error("rom revision read wrong");
   chk_ram_read: assert property (req.rd && req.addr == DSR_OFS_RAM_REV && $stable(ram_revision)
      |=> rd_data == $past(ram_revision)) else $error("patch revision read wrong");
   chk_valid_pulse: assert property ($past(rst_n) |-> rd_valid == $past(req.rd))
      else $error("read answer strobe wrong");
   chk_gain_calc: assert property ($past(rst_n) |-> gain_product == $past(exp_gain))
      else $error("gain product wrong");
   chk_irq_change: assert property (rst_n && $past(rst_n) && $changed(src) |-> ##2 irq_asserted)
      else $error("change did not raise interrupt");
   chk_prot_read: assert property (req.rd && req.addr == DSR_OFS_SIGNAL_STAT |=>
      rd_data[7] == 1'b0 && rd_data[2:0] == $past(status.copy_prot)) else $error("protection code wrong");
   chk_gain_read: assert property (req.rd && req.addr == DSR_OFS_GAIN_READ |=>
      rd_data == {$past(status.analog_gain), $past(status.digital_gain[5:2])}) else $error("gain byte wrong");
   chk_pin_high: assert property (irq_pin_out |-> irq_pin_oe && irq_asserted)
      else $error("pin high while idle");
   chk_pin_idle: assert property (!irq_pin_oe |-> !irq_asserted)
      else $error("pin released while active");
   chk_wire_read: assert property (req.rd && req.addr == DSR_OFS_IRQ_ACTIVE && $stable(irq_asserted)
      |=> rd_data == {7'h00, $past(irq_asserted)}) else $error("pin state read wrong");
endmodule : dsr_top_asserts

bind dsr_top dsr_top_asserts #(.ROM_REVISION(ROM_REVISION)) i_chk (.clk(clk), .rst_n(rst_n), .req(req),
   .rd_data(rd_data), .rd_valid(rd_valid), .status(status), .ram_revision(ram_revision),
   .irq_pin_out(irq_pin_out), .irq_pin_oe(irq_pin_oe), .irq_asserted(irq_asserted), .gain_product(gain_product));

// ---- verif/dsr_host_model.sv ----
// host model: single byte register reads and writes on the request port
module dsr_host_model
   import dsr_pkg::*;
(
   input  wire logic       clk,
   input  wire logic [7:0] rd_data,
   input  wire logic       rd_valid,
   output dsr_req_t        req
);
   timeunit 1ns;
   timeprecision 1ps;
   initial req = '0;
   // release: strobes low, address and data inverted so stale values never look valid
   task automatic drop;
      req <= '{rd: 1'b0, wr: 1'b0, addr: ~req.addr, wdata: ~req.wdata};
   endtask : drop
   // one-cycle write strobe; a one at the clear address acknowledges that flag
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      req <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
      @(posedge clk);
      drop();
   endtask : wr_reg
   // answer is taken one cycle after the strobe, once it has settled
   task automatic rd_reg(input logic [7:0] a, output logic [7:0] d, output logic v);
      @(posedge clk);
      req <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: req.wdata};
      @(posedge clk);
      drop();
      #1;
      v = rd_valid;
      d = rd_data;
   endtask : rd_reg
endmodule : dsr_host_model

// ---- verif/test_decoder_status_readback.sv ----
// testbench: status readback bank against a bench model of its registers
module test_decoder_status_readback
   import dsr_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [7:0] ROM_REV = 8'h3c;  // arbitrary value
   localparam int STEP [16] = '{61, 55, 48, 44, 38, 33, 29, 26, 24, 22, 20, 19, 18, 17, 16, 15};
   localparam int SRC [6] = '{0, 1, 2, 3, 4, 6};
   logic                  clk = 1'b0;
   logic                  rst_n = 1'b0;
   logic                  line_start = 1'b0;
   logic                  frame_start = 1'b0;
   logic [7:0]            ram_rev = 8'h00;
   dsr_status_t           st = '0;
   dsr_status_t           nxt_st;
   dsr_req_t              req;
   logic [7:0]            rd_data;
   logic                  rd_valid, irq_pin_out, irq_pin_oe, irq_asserted;
   logic [DSR_PROD_W-1:0] gain_product;
   logic [15:0]           seed = 16'h61f9;
   int                    miscompares = 0;
   int                    checked = 0;
   int                    cycles = 0;
   wire                   irq_wire = irq_pin_oe ? irq_pin_out : 1'b1;  // pull-up when released

   always #2.5 clk = ~clk;
   dsr_top #(.ROM_REVISION(ROM_REV)) i_dut (.clk(clk), .rst_n(rst_n), .req(req), .rd_data(rd_data),
      .rd_valid(rd_valid), .status(st), .ram_revision(ram_rev), .line_start(line_start),
      .frame_start(frame_start), .irq_pin_in(irq_wire), .irq_pin_out(irq_pin_out), .irq_pin_oe(irq_pin_oe),
      .irq_asserted(irq_asserted), .gain_product(gain_product));
   dsr_host_model i_host (.clk(clk), .rd_data(rd_data), .rd_valid(rd_valid), .req(req));
   ////////////////////////////////////////////////////////////////////////////
   function automatic logic [15:0] rnd();
      seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
      return seed;
   endfunction : rnd
   function automatic logic [7:0] lock_byte(input logic lost);
      return {st.peak_white, st.line_alt, st.field_50hz, lost, st.subcarrier_lock, st.vsync_lock,
              st.hsync_lock, st.source_class};
   endfunction : lock_byte
   task automatic check(input logic [31:0] seen, input logic [31:0] want);
      checked++;
      if (seen !== want) begin
         miscompares++;
         $display("wrong value at %0t: saw %h expected %h", $time, seen, want);
      end
   endtask : check
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] want);
      logic [7:0] d;
      logic       v;
      i_host.rd_reg(a, d, v);
      check({23'h0, v, d}, {23'h0, 1'b1, want});  // byte with its strobe, compared in one check
   endtask : rd_chk
   // frame_start counts as the first line, so n pulses give n+1
   task automatic send_frame(input int n);
      frame_start <= 1'b1;
      @(posedge clk);
      frame_start <= 1'b0;
      repeat (n) begin
         @(posedge clk);
         line_start <= 1'b1;
         @(posedge clk);
         line_start <= 1'b0;
      end
      @(posedge clk);
   endtask : send_frame
   task automatic final_report;
      $display("comparisons %0d, mismatches %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : final_report
   // hang guard, well above the roughly 2000 to 3000 cycles of the run
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         miscompares++;
         final_report();
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      logic [15:0] r;
      int          n;
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      r = rnd();
      ram_rev <= r[7:0];  // host has loaded a newer patch
      st.init_done <= 1'b1;
      // drop any flag left over from reset release before the readback checks
      i_host.wr_reg(DSR_OFS_IRQ_RESET, 8'hff);
      i_host.wr_reg(DSR_OFS_ROM_REV, 8'hff);
      i_host.wr_reg(DSR_OFS_RAM_REV, ~r[7:0]);
      i_host.wr_reg(DSR_OFS_IRQ_FLAGS, 8'h7f);
      i_host.wr_reg(DSR_OFS_LINE_LOW, 8'hff);
      rd_chk(DSR_OFS_ROM_REV, ROM_REV);
      rd_chk(DSR_OFS_RAM_REV, r[7:0]);
      rd_chk(DSR_OFS_IRQ_FLAGS, 8'h80);
      rd_chk(DSR_OFS_LINE_LOW, 8'h00);
      rd_chk(DSR_OFS_IRQ_CONFIG, 8'h00);
      rd_chk(DSR_OFS_IRQ_ACTIVE, 8'h00);
      rd_chk(8'h90, 8'h00);
      $display("test registers done");
      // random status levels, every protection code once
      for (int i = 0; i < 8; i++) begin
         r = rnd();
         nxt_st = st;
         {nxt_st.peak_white, nxt_st.line_alt, nxt_st.field_50hz, nxt_st.source_class, nxt_st.weak_signal,
          nxt_st.phase_alternation_toggle, nxt_st.odd_field, nxt_st.gain_frozen} = r[7:0];
         {nxt_st.analog_gain, nxt_st.digital_gain} = r[15:6];
         nxt_st.copy_prot = 3'(i);
         @(posedge clk);
         st <= nxt_st;
         repeat (2) @(posedge clk);
         rd_chk(DSR_OFS_LOCK_STATUS, lock_byte(1'b0));
         rd_chk(DSR_OFS_SIGNAL_STAT, {1'b0, nxt_st.weak_signal, nxt_st.phase_alternation_toggle,
                nxt_st.odd_field, nxt_st.gain_frozen, nxt_st.copy_prot});
         rd_chk(DSR_OFS_GAIN_READ, {nxt_st.analog_gain, nxt_st.digital_gain[5:2]});
      end
      $display("test status done");
      // every analog setting, digital at its top value for the last
      for (int a = 0; a < 16; a++) begin
         r = rnd();
         nxt_st = st;
         nxt_st.analog_gain = 4'(a);
         nxt_st.digital_gain = (a == 15) ? 6'h3f : r[5:0];
         @(posedge clk);
         st <= nxt_st;
         repeat (2) @(posedge clk);
         #1 check(32'(gain_product), (15 + 3 * a) * (4096 + STEP[a] * int'(nxt_st.digital_gain)));
      end
      $display("test gain done");
      // each change source raises, drives the pin and is cleared, both polarities
      for (int p = 0; p < 2; p++) begin
         i_host.wr_reg(DSR_OFS_IRQ_CONFIG, 8'(p));
         rd_chk(DSR_OFS_IRQ_CONFIG, 8'(p));
         i_host.wr_reg(DSR_OFS_IRQ_RESET, 8'hff);
         foreach (SRC[k]) begin
            nxt_st = st;
            case (SRC[k])
               0: nxt_st.source_class = ~st.source_class;
               1: nxt_st.hsync_lock = ~st.hsync_lock;
               2: nxt_st.subcarrier_lock = ~st.subcarrier_lock;
               3: nxt_st.line_alt = ~st.line_alt;
               4: nxt_st.field_50hz = ~st.field_50hz;
               default: nxt_st.copy_prot = st.copy_prot ^ 3'h1;
            endcase
            @(posedge clk);
            st <= nxt_st;
            repeat (3) @(posedge clk);
            rd_chk(DSR_OFS_IRQ_FLAGS, 8'h80 | (8'h01 << SRC[k]));
            rd_chk(DSR_OFS_IRQ_ACTIVE, 8'h01);
            check({29'h0, irq_asserted, irq_pin_oe, irq_pin_out}, {29'h0, 2'b11, 1'(p)});
            i_host.wr_reg(DSR_OFS_IRQ_RESET, 8'h01 << SRC[k]);
            rd_chk(DSR_OFS_IRQ_FLAGS, 8'h80);
            rd_chk(DSR_OFS_IRQ_ACTIVE, 8'h00);
            check({29'h0, irq_asserted, irq_pin_oe, irq_pin_out}, {29'h0, 1'b0, 1'(p), 1'b0});
         end
      end
      $display("test flags done");
      // horizontal lock fell above; the read clears it, a vertical fall sets it again
      rd_chk(DSR_OFS_LOCK_STATUS, lock_byte(1'b1));
      rd_chk(DSR_OFS_LOCK_STATUS, lock_byte(1'b0));
      @(posedge clk);
      st.vsync_lock <= 1'b1;
      repeat (2) @(posedge clk);
      st.vsync_lock <= 1'b0;
      repeat (2) @(posedge clk);
      rd_chk(DSR_OFS_LOCK_STATUS, lock_byte(1'b1));
      $display("test lost lock done");
      // a standard-length frame, then a random nonstandard one
      for (int j = 0; j < 2; j++) begin
         r = rnd();
         n = (j == 0) ? 624 : 200 + int'(r[8:0]);
         @(posedge clk);
         send_frame(n);
         send_frame(0);
         rd_chk(DSR_OFS_LINE_HIGH, 8'((n + 1) >> 8));
         rd_chk(DSR_OFS_LINE_LOW, 8'(n + 1));
      end
      $display("test line count done");
      final_report();
   end
endmodule : test_decoder_status_readback
